//--- core/pdt_pkg.sv
/*
  constants for the periodic down timer: register offsets, field positions, widths.
  assumes a 12-bit byte address inside a 4K window and 32-bit register words.
*/
package pdt_pkg;
  localparam int unsigned CNT_W = 24;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam logic [11:0] OFS_CSR = 12'h000;
  localparam logic [11:0] OFS_RLD = 12'h004;
  localparam logic [11:0] OFS_CNT = 12'h008;
  localparam logic [11:0] OFS_RSVD = 12'h00C;
  localparam int unsigned CSR_EN_BIT = 0;
  localparam int unsigned CSR_IE_BIT = 1;
  localparam int unsigned CSR_SRC_BIT = 2;
  localparam int unsigned CSR_FLAG_BIT = 16;
  localparam logic [7:0] IRQ_VECTOR = 8'h18;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;
endpackage : pdt_pkg

//--- core/pdt_cnt_if.sv
/*
  carrier between the timer register logic and its down-counter.
  assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
interface pdt_cnt_if #(parameter int W = 24);
  logic tick;
  logic run;
  logic clr;
  logic rd_clr;
  logic [W-1:0] reload;
  logic [W-1:0] count;
  logic flag;
  logic reach;
  modport ctl (output tick, output run, output clr, output rd_clr, output reload,
               input count, input flag, input reach);
  modport cnt (input tick, input run, input clr, input rd_clr, input reload,
               output count, output flag, output reach);
endinterface : pdt_cnt_if

//--- core/pdt_sync.sv
/*
  three-flop synchroniser with agreement filter for an asynchronous level.
  assumes the input is slower than a quarter of the local clock.
*/
`timescale 1ns/10ps
module pdt_sync (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic async_in,
  output logic level_out
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic level_ff;
  wire agree = (s2_ff == s3_ff);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      level_ff <= 1'b0;
    end else begin
      s1_ff <= async_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (agree) begin
        level_ff <= s3_ff;
      end
    end
  end

  assign level_out = level_ff;
endmodule : pdt_sync

//--- core/pdt_counter.sv
/*
  24-bit reload down-counter with zero-reached flag.
  assumes tick, run and clear strobes come from the register block on the same clock.
*/
`timescale 1ns/10ps
module pdt_counter #(parameter int W = 24) (
  input wire logic clk_in,
  input wire logic rst_in,
  pdt_cnt_if.cnt cb
);
  logic [W-1:0] count_ff;
  logic [W-1:0] nxt_count;
  logic flag_ff;
  logic nxt_flag;

  // the count must fit one register word and leave room for a reload of one
  if (W < 2 || W > 32) begin : g_bad_width
    $error("counter width out of range");
  end

  wire step = cb.tick & cb.run & ~cb.clr;
  wire at_zero = (count_ff == '0);
  wire [W-1:0] one = {{(W-1){1'b0}}, 1'b1};
  wire reach = step & (count_ff == one);

  // a zero reload is loaded like any other, so the counter parks at zero
  assign nxt_count = cb.clr ? '0 :
                     !step ? count_ff :
                     at_zero ? cb.reload :
                     count_ff - one;
  // set wins over a read clear; a count write clears and blocks the set
  assign nxt_flag = reach | (flag_ff & ~cb.clr & ~cb.rd_clr);

  // count has no reset value on purpose
  always_ff @(posedge clk_in) begin
    count_ff <= nxt_count;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      flag_ff <= 1'b0;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  assign cb.count = count_ff;
  assign cb.flag = flag_ff;
  assign cb.reach = reach;
endmodule : pdt_counter

//--- core/pdt_timer.sv
/*
  periodic down timer top: register port, count clock selection, interrupt request.
  assumes a one-cycle strobe register master on clk_in and an asynchronous reference clock pin.
*/
// Decided for this implementation: the strobed register port.
`timescale 1ns/10ps
// Summary of operation
// - while enabled the 24-bit count steps down once per count clock and reloads after zero.
// - a zero reload leaves the counter parked at zero after the next wrap.
// - the zero-reached flag goes to 1 when the count reaches zero.
// - reaching zero raises the interrupt request only when the interrupt enable is 1.
// - a read of the control/status register clears the zero-reached flag unless zero is reached in that same cycle.
// - any write to the count register clears the count and the flag, data ignored.
// - a read of the count register returns the live count.
// - the count clock is the core clock when the source bit is 1, else the reference clock.
// - the counter only steps while the counting enable bit is 1.
// - reset clears the flag, the source select, the interrupt enable and counting enable.
// - reload and count registers have no reset value.
// - a 4K window holds control/status, reload, count and one reserved word.
// - the interrupt request goes out with exception vector 24.
module pdt_timer (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ref_clk_in,
  input wire logic [pdt_pkg::ADDR_W-1:0] addr_in,
  input wire logic [pdt_pkg::DATA_W-1:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  output logic [pdt_pkg::DATA_W-1:0] rd_data_out,
  output logic irq_out,
  output logic [7:0] irq_vector_out
);
  localparam int W = pdt_pkg::CNT_W;

  // the status word and the count must both fit in one register word
  if (pdt_pkg::CNT_W > pdt_pkg::DATA_W ||
      pdt_pkg::CSR_FLAG_BIT >= pdt_pkg::DATA_W) begin : g_bad_map
    $error("counter width or status layout does not fit the register word");
  end

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic en_ff;
  logic ie_ff;
  logic src_ff;
  logic [W-1:0] rld_ff;
  logic ref_prev_ff;
  logic [pdt_pkg::DATA_W-1:0] rd_data_ff;
  logic irq_ff;
  logic [7:0] vec_ff;
  logic ref_lvl;

  pdt_cnt_if #(.W(W)) cb ();

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  wire sel_csr = (addr_in == pdt_pkg::OFS_CSR);
  wire sel_rld = (addr_in == pdt_pkg::OFS_RLD);
  wire sel_cnt = (addr_in == pdt_pkg::OFS_CNT);
  wire wr_csr = wr_en_in & sel_csr;
  wire wr_rld = wr_en_in & sel_rld;
  wire wr_cnt = wr_en_in & sel_cnt;
  wire rd_csr = rd_en_in & sel_csr;

  wire [pdt_pkg::DATA_W-1:0] csr_view =
    (pdt_pkg::DATA_W'(en_ff) << pdt_pkg::CSR_EN_BIT) |
    (pdt_pkg::DATA_W'(ie_ff) << pdt_pkg::CSR_IE_BIT) |
    (pdt_pkg::DATA_W'(src_ff) << pdt_pkg::CSR_SRC_BIT) |
    (pdt_pkg::DATA_W'(cb.flag) << pdt_pkg::CSR_FLAG_BIT);
  // reserved word and unmapped offsets read as zero
  wire [pdt_pkg::DATA_W-1:0] nxt_rd_data =
    !rd_en_in ? pdt_pkg::READ_ZERO :
    sel_csr ? csr_view :
    sel_rld ? pdt_pkg::DATA_W'(rld_ff) :
    sel_cnt ? pdt_pkg::DATA_W'(cb.count) :
    pdt_pkg::READ_ZERO;

  ////////////////////////////////////////////////////////////////////////////
  // count clock select

  pdt_sync u_ref_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .async_in(ref_clk_in),
    .level_out(ref_lvl)
  );

  // reference clock must stay below a quarter of the core clock to be seen
  wire ref_rise = ref_lvl & ~ref_prev_ff;
  wire nxt_tick = src_ff ? 1'b1 : ref_rise;

  assign cb.tick = nxt_tick;
  assign cb.run = en_ff;
  assign cb.clr = wr_cnt;
  assign cb.rd_clr = rd_csr;
  assign cb.reload = rld_ff;

  pdt_counter #(.W(W)) u_counter (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .cb(cb.cnt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // registers

  wire nxt_irq = cb.flag & ie_ff;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      en_ff <= 1'b0;
      ie_ff <= 1'b0;
      src_ff <= 1'b0;
      ref_prev_ff <= 1'b0;
      rd_data_ff <= pdt_pkg::READ_ZERO;
      irq_ff <= 1'b0;
      vec_ff <= pdt_pkg::IRQ_VECTOR;
    end else begin
      if (wr_csr) begin
        en_ff <= wr_data_in[pdt_pkg::CSR_EN_BIT];
        ie_ff <= wr_data_in[pdt_pkg::CSR_IE_BIT];
        src_ff <= wr_data_in[pdt_pkg::CSR_SRC_BIT];
      end
      ref_prev_ff <= ref_lvl;
      rd_data_ff <= nxt_rd_data;
      irq_ff <= nxt_irq;
      vec_ff <= pdt_pkg::IRQ_VECTOR;
    end
  end

  // reload carries no reset value; software must write it before enabling
  always_ff @(posedge clk_in) begin
    if (wr_rld) begin
      rld_ff <= wr_data_in[W-1:0];
    end
  end

  assign rd_data_out = rd_data_ff;
  assign irq_out = irq_ff;
  assign irq_vector_out = vec_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb_clk @(posedge clk_in); endclocking
  default disable iff (rst_in);

  wire stepping = cb.tick & cb.run & ~cb.clr;
  wire wrap_step = stepping & (cb.count == '0);
  wire sel_none = ~sel_csr & ~sel_rld & ~sel_cnt;

  // the count has no reset value, so stability checks wait for its first clear
  logic cnt_known_ff;
  // steps since the last wrap; a reload or count write spoils the measurement
  logic [W-1:0] gap_ff;
  logic gap_ok_ff;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_known_ff <= 1'b0;
    end else if (wr_cnt) begin
      cnt_known_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      gap_ff <= '0;
      gap_ok_ff <= 1'b0;
    end else if (wrap_step) begin
      gap_ff <= '0;
      gap_ok_ff <= ~wr_rld;
    end else begin
      gap_ff <= stepping ? gap_ff + W'(1) : gap_ff;
      gap_ok_ff <= gap_ok_ff & ~wr_cnt & ~wr_rld;
    end
  end

  sequence s_wrap_arm;
    stepping && cb.count == '0;
  endsequence

  sequence s_last_step;
    stepping && cb.count == W'(1);
  endsequence

  a_count_step: assert property (stepping && cb.count != '0 |=>
    cb.count == $past(cb.count) - W'(1))
    else $error("count did not step down by one");

  a_wrap_reload: assert property (s_wrap_arm |=> cb.count == $past(rld_ff))
    else $error("count did not reload after zero");

  a_zero_parks: assert property ((s_wrap_arm and rld_ff == '0)
    ##1 (!cb.clr && rld_ff == '0) |=> cb.count == '0)
    else $error("zero reload started a new period");

  a_flag_on_zero: assert property (s_last_step |=> cb.flag && cb.count == '0)
    else $error("flag not set on reaching zero");

  a_irq_gated: assert property (cb.flag && !ie_ff |=> !irq_out)
    else $error("request raised with interrupt disabled");

  a_csr_rd_clear: assert property (rd_csr && !cb.reach |=> !cb.flag)
    else $error("status read left the flag set");

  a_cnt_wr_clear: assert property (wr_cnt |=> cb.count == '0 && !cb.flag)
    else $error("count write did not clear count and flag");

  a_cnt_read_live: assert property (rd_en_in && sel_cnt |=>
    rd_data_out == pdt_pkg::DATA_W'($past(cb.count)))
    else $error("count read returned a stale value");

  a_core_src_tick: assert property (src_ff && en_ff && !wr_cnt && cb.count > W'(1)
    |=> cb.count == $past(cb.count) - W'(1))
    else $error("core clock source did not step every cycle");

  a_hold_disabled: assert property (cnt_known_ff && !en_ff && !wr_cnt |=>
    $stable(cb.count))
    else $error("count moved while disabled");

  a_irq_held: assert property (cb.flag && ie_ff ##1 cb.flag && ie_ff
    |-> irq_out)
    else $error("request dropped while flag and enable are set");

  a_irq_vector: assert property (irq_out |-> irq_vector_out == pdt_pkg::IRQ_VECTOR)
    else $error("wrong exception vector");

  a_rd_idle_zero: assert property (!rd_en_in |=>
    rd_data_out == pdt_pkg::READ_ZERO)
    else $error("read data not zero outside a read");

  a_rsvd_read_zero: assert property (rd_en_in && sel_none |=>
    rd_data_out == pdt_pkg::READ_ZERO)
    else $error("unmapped read returned data");

  a_rsvd_write_ignored: assert property (wr_en_in && sel_none |=>
    $stable(rld_ff) && $stable(en_ff) && $stable(ie_ff) && $stable(src_ff))
    else $error("unmapped write changed a register");

  a_rld_write: assert property (wr_rld |=>
    rld_ff == $past(wr_data_in[W-1:0]))
    else $error("reload write not taken");

  a_rld_read_back: assert property (rd_en_in && sel_rld |=>
    rd_data_out == pdt_pkg::DATA_W'($past(rld_ff)))
    else $error("reload read returned the wrong value");

  a_csr_write: assert property (wr_csr |=>
    {en_ff, ie_ff, src_ff} == $past({wr_data_in[pdt_pkg::CSR_EN_BIT],
    wr_data_in[pdt_pkg::CSR_IE_BIT], wr_data_in[pdt_pkg::CSR_SRC_BIT]}))
    else $error("control write not taken");

  a_csr_rd_fields: assert property (rd_csr |=>
    rd_data_out[pdt_pkg::CSR_EN_BIT] == $past(en_ff) &&
    rd_data_out[pdt_pkg::CSR_IE_BIT] == $past(ie_ff) &&
    rd_data_out[pdt_pkg::CSR_SRC_BIT] == $past(src_ff))
    else $error("control read returned the wrong fields");

  a_csr_flag_view: assert property (rd_csr |=>
    rd_data_out[pdt_pkg::CSR_FLAG_BIT] == $past(cb.flag))
    else $error("status read did not show the flag");

  a_cnt_rd_upper: assert property (rd_en_in && sel_cnt |=>
    rd_data_out[pdt_pkg::DATA_W-1:W] == '0)
    else $error("count read set bits above the count");

  a_flag_only_zero: assert property (!cb.flag && !cb.reach |=>
    !cb.flag)
    else $error("flag rose without reaching zero");

  a_flag_stays: assert property (cb.flag && !rd_csr && !wr_cnt |=>
    cb.flag)
    else $error("flag dropped without a clear");

  a_wrap_no_flag: assert property ((s_wrap_arm and !cb.flag) |=>
    !cb.flag)
    else $error("reload after zero set the flag");

  a_irq_raise: assert property (cb.flag && ie_ff |=>
    irq_out)
    else $error("request missing with flag and enable set");

  a_irq_drop: assert property (!(cb.flag && ie_ff) |=>
    !irq_out)
    else $error("request held after flag or enable cleared");

  a_ref_tick_only: assert property (!src_ff && !ref_rise && !wr_cnt &&
    cnt_known_ff |=> $stable(cb.count))
    else $error("count moved without a reference edge");

  a_ref_step: assert property (!src_ff && en_ff && ref_rise && !wr_cnt &&
    cb.count > W'(1) |=> cb.count == $past(cb.count) - W'(1))
    else $error("reference edge did not step the count");

  a_period_len: assert property (gap_ok_ff && cb.reach |->
    gap_ff == rld_ff - W'(1))
    else $error("period between wraps differs from the reload");

  a_reset_clear: assert property (disable iff (1'b0) rst_in |=>
    !en_ff && !ie_ff && !src_ff && !cb.flag && !irq_out)
    else $error("reset left a control bit or the flag set");
endmodule : pdt_timer

//--- bench/test_pdt_timer.sv
/*
  self-checking bench for the periodic down timer, with a cycle model of the registers.
  assumes pdt_pkg and pdt_timer are compiled first; assertions live in the design files.
*/
`timescale 1ns/10ps
module test_pdt_timer;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic ref_clk_in = 1'b0;
  logic [11:0] addr_in = 12'h000;
  logic [31:0] wr_data_in = 32'h0000_0000;
  logic wr_en_in = 1'b0;
  logic rd_en_in = 1'b0;
  logic [31:0] rd_data_out;
  logic irq_out;
  logic [7:0] irq_vector_out;
  int error_cnt = 0;
  int checks_done = 0;
  int m_en, m_ie, m_src, m_flag, m_cnt, m_rld, m_irq, m_rd, tick;
  int ref_tick = 0;
  logic [11:0] ofs [4] = '{12'h00C, 12'h010, 12'hFFC, 12'h002};

  always #2.5 clk_in = ~clk_in;

  pdt_timer dut (.clk_in(clk_in), .rst_in(rst_in), .ref_clk_in(ref_clk_in),
    .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
    .rd_data_out(rd_data_out), .irq_out(irq_out), .irq_vector_out(irq_vector_out));

  ////////////////////////////////////////////////////////////////////////////////
  // model: works on the state before each edge, like the registers it mirrors
  always @(posedge clk_in) begin
    if (rst_in) begin
      m_en = 0; m_ie = 0; m_src = 0; m_flag = 0; m_irq = 0; m_rd = 0;
    end else begin
      m_irq = m_flag & m_ie;
      m_rd = 0;
      if (rd_en_in && addr_in == 12'h000) m_rd = m_en | m_ie << 1 | m_src << 2 | m_flag << 16;
      if (rd_en_in && addr_in == 12'h004) m_rd = m_rld;
      if (rd_en_in && addr_in == 12'h008) m_rd = m_cnt;
      if (rd_en_in && addr_in == 12'h000) m_flag = 0;
      tick = m_en && (m_src != 0 || ref_tick != 0);
      ref_tick = 0;
      if (wr_en_in && addr_in == 12'h008) begin
        m_cnt = 0;
        m_flag = 0;
      end else if (tick) begin
        if (m_cnt != 0) begin
          m_cnt--;
          if (m_cnt == 0) m_flag = 1;
        end else m_cnt = m_rld;
      end
      if (wr_en_in && addr_in == 12'h000) begin
        m_en = wr_data_in[0]; m_ie = wr_data_in[1]; m_src = wr_data_in[2];
      end
      if (wr_en_in && addr_in == 12'h004) m_rld = wr_data_in[23:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, s);
      error_cnt++;
    end
  endtask : chk

  // outputs are settled by the falling edge
  always @(negedge clk_in) begin
    if (!rst_in) begin
      chk("rd_data_out", m_rd, rd_data_out);
      chk("irq_out", m_irq, irq_out);
      chk("irq_vector_out", 32'h0000_0018, irq_vector_out);
    end
  end

  task automatic end_of_test;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wr_data_in <= d;
    wr_en_in <= 1'b1;
    @(posedge clk_in);
    wr_en_in <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a);
    @(posedge clk_in);
    addr_in <= a;
    rd_en_in <= 1'b1;
    @(posedge clk_in);
    rd_en_in <= 1'b0;
  endtask : rd

  task automatic run(input int n);
    repeat (n) @(posedge clk_in);
  endtask : run

  // bounded wait; a run-out ends the test
  task automatic wait_irq;
    int n;
    n = 0;
    while (irq_out !== 1'b1 && n < 100) begin
      @(negedge clk_in);
      n++;
    end
    if (n >= 100) begin
      error_cnt++;
      $display("ERROR irq_out expected 1 seen %b", irq_out);
      end_of_test();
    end
  endtask : wait_irq

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(50));
    run(6);
    rst_in <= 1'b0;
    rd(12'h000);
    wr(12'h004, 32'hFF00_0002);
    wr(12'h008, $urandom);
    wr(12'h000, 32'h0000_0007);
    wait_irq();
    run(20);
    rd(12'h000);
    rd(12'h000);
    wr(12'h000, 32'h0000_0005);
    run(12);
    wr(12'h008, $urandom);
    rd(12'h008);
    wr(12'h000, 32'h0000_0004);
    run(5);
    rd(12'h008);
    for (int i = 0; i < 4; i++) begin
      wr(12'h004, $urandom_range(15, 1));
      wr(12'h000, 32'h0000_0007);
      run(40);
      rd(12'h004);
      rd(12'h000);
    end
    wr(12'h004, 32'h0000_0000);
    run(30);
    rd(12'h008);
    wr(12'h004, 32'h00FF_FFFF);
    wr(12'h008, 32'h0000_0000);
    run(10);
    rd(12'h008);
    foreach (ofs[i]) begin
      wr(ofs[i], $urandom);
      rd(ofs[i]);
    end
    // reference clock: still at first, then five slow pulses
    wr(12'h000, 32'h0000_0001);
    wr(12'h008, 32'h0000_0000);
    wr(12'h004, 32'h0000_0100);
    run(10);
    rd(12'h008);
    repeat (5) begin
      @(posedge clk_in);
      ref_clk_in <= 1'b1;
      ref_tick <= 1;
      run(10);
      ref_clk_in <= 1'b0;
      run(10);
    end
    rd(12'h008);
    wr(12'h000, 32'h0000_0007);
    @(posedge clk_in);
    rst_in <= 1'b1;
    run(2);
    rst_in <= 1'b0;
    rd(12'h000);
    run(3);
    end_of_test();
  end
endmodule : test_pdt_timer
